/* logic/tcp_consts.vh */
// Shared constants of the four-channel timer, counter and PWM unit.
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH

// ============================================================
// Register map: byte address = channel * stride + offset.
`define TCP_OFS_LSB         2
`define TCP_OFS_MSB         4
`define TCP_CH_LSB          5
`define TCP_CH_MSB          6
`define TCP_BANK_BIT        7
`define TCP_OFS_CTRL        3'h0
`define TCP_OFS_PERIOD      3'h1
`define TCP_OFS_COMPARE     3'h2
`define TCP_OFS_COUNT       3'h3
`define TCP_OFS_CAPTURE     3'h4
`define TCP_OFS_STATUS      3'h5

// ============================================================
// Control register fields.
`define TCP_CTRL_EN         0
`define TCP_CTRL_START      1
`define TCP_CTRL_MODE       2
`define TCP_CTRL_REL        4
`define TCP_CTRL_SRC        7
`define TCP_CTRL_COMP       9
`define TCP_CTRL_DB         16

// ============================================================
// Run modes and compare relations.
`define TCP_MODE_FREE       2'h0
`define TCP_MODE_ONESHOT    2'h1
`define TCP_MODE_GATED      2'h2
`define TCP_REL_LESS        3'h0
`define TCP_REL_LESS_EQUAL  3'h1
`define TCP_REL_EQUAL       3'h2
`define TCP_REL_GREATER_EQ  3'h3
`define TCP_REL_GREATER     3'h4

// ============================================================
// Reset values.
`define TCP_PERIOD_RST      16'hffff
`define TCP_COMPARE_RST     16'h0000
`define TCP_COUNT_RST       16'hffff
`define TCP_DB_RST          8'h00
`define TCP_WORD_ZERO       32'h0000_0000

`endif

/* logic/tcp_deadband.v */
// Deadband generator that splits one PWM level into a true and complementary pair.
`timescale 1ns/100ps
`default_nettype none

module tcp_deadband #(
    parameter DBW = 8
) (
    // Clock and reset.
    input  wire           clk,
    input  wire           rst,
    // Control.
    input  wire           pwm_in,
    input  wire           comp_en,
    input  wire           kill,
    input  wire [DBW-1:0] db_len,
    // Outputs.
    output reg            out_p,
    output reg            out_n
);

    reg           prev_ff;
    reg [DBW-1:0] dly_ff;
    wire          change;
    wire          settled;

    assign change  = pwm_in ^ prev_ff;
    assign settled = ~change & (dly_ff == {DBW{1'b0}});

    // ============================================================
    // Gap timer.
    // Every edge of the level restarts the gap, so both sides stay low for
    // db_len + 1 cycles; the leaving side drops at once.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
            dly_ff  <= {DBW{1'b0}};
        end else begin
            prev_ff <= pwm_in;
            if (change) begin
                dly_ff <= db_len;
            end else if (dly_ff != {DBW{1'b0}}) begin
                dly_ff <= dly_ff - {{(DBW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ============================================================
    // Output pair.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_p <= 1'b0;
            out_n <= 1'b0;
        end else if (kill) begin
            out_p <= 1'b0;
            out_n <= 1'b0;
        end else if (!comp_en) begin
            out_p <= pwm_in;
            out_n <= 1'b0;
        end else begin
            out_p <= pwm_in & settled;
            out_n <= ~pwm_in & settled;
        end
    end

endmodule
`default_nettype wire

/* logic/tcp_top.v */
// Four-channel 16-bit down-counting timer, counter and PWM unit with register port.
//
// Contract
// - Each channel is a 16-bit counter that only counts down.
// - Four independent timer, counter and PWM channels are provided.
// - Each channel picks its count tick from several selectable sources.
// - Each channel drives compare, terminal count and optional complementary compare outputs.
// - Compare relation selectable: less, less-equal, equal, greater-equal, greater.
// - Period reloads on start, on the reset input and at terminal count.
// - Run modes are free running, one-shot and enable-gated counting.
// - One-shot mode halts at end of period instead of reloading.
// - Gated mode counts only on ticks while enable input is high.
// - Timer reset and capture inputs; capture stores the full 16-bit count.
// - Kill input forces both compare outputs inactive regardless of comparator.
// - True and complementary outputs are separated by a deadband, never both high.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tcp_consts.vh"

module tcp_top #(
    parameter NCH = 4,
    parameter CW  = 16,
    parameter DBW = 8,
    parameter AW  = 8
) (
    // Clock and reset.
    input  wire            clk,
    input  wire            rst,
    // Register port.
    input  wire [AW-1:0]   addr,
    input  wire [31:0]     wdata,
    input  wire            wr,
    input  wire            rd,
    output reg  [31:0]     rdata,
    // Count tick sources beside the system clock.
    input  wire [2:0]      src_tick_in,
    // Per-channel control inputs.
    input  wire [NCH-1:0]  cap_in,
    input  wire [NCH-1:0]  trst_in,
    input  wire [NCH-1:0]  en_in,
    input  wire [NCH-1:0]  kill_in,
    // Per-channel outputs.
    output wire [NCH-1:0]  cmp_out,
    output wire [NCH-1:0]  cmp_n_out,
    output wire [NCH-1:0]  tc_out
);

    // ============================================================
    // Channel run states.
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_HALT = 3'b100;

    // ============================================================
    // Address decode shared by all channels.
    wire [2:0]        ofs;
    wire [1:0]        ch_sel;
    wire              bank_ok;
    wire [NCH*32-1:0] ch_rd;

    assign ofs     = addr[`TCP_OFS_MSB:`TCP_OFS_LSB];
    assign ch_sel  = addr[`TCP_CH_MSB:`TCP_CH_LSB];
    assign bank_ok = ~addr[`TCP_BANK_BIT];

    // ============================================================
    // Comparator relation between the count and the compare value.
    function cmp_rel;
        input [2:0]    rel;
        input [CW-1:0] cnt;
        input [CW-1:0] val;
        begin
            case (rel)
                `TCP_REL_LESS:       cmp_rel = (cnt <  val);
                `TCP_REL_LESS_EQUAL: cmp_rel = (cnt <= val);
                `TCP_REL_EQUAL:      cmp_rel = (cnt == val);
                `TCP_REL_GREATER_EQ: cmp_rel = (cnt >= val);
                `TCP_REL_GREATER:    cmp_rel = (cnt >  val);
                default:             cmp_rel = 1'b0;
            endcase
        end
    endfunction

    // ============================================================
    // Channels.
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            reg  [CW-1:0]  period_ff;
            reg  [CW-1:0]  compare_ff;
            reg  [CW-1:0]  cnt_ff;
            reg  [CW-1:0]  cap_ff;
            reg            en_ff;
            reg            comp_ff;
            reg  [1:0]     mode_ff;
            reg  [1:0]     src_ff;
            reg  [2:0]     rel_ff;
            reg  [DBW-1:0] db_ff;
            reg  [2:0]     st_ff;
            reg            tc_ff;
            reg            cap_prev_ff;
            reg            cap_full_ff;
            reg  [CW-1:0]  nxt_cnt;
            reg  [2:0]     nxt_st;
            reg  [31:0]    rd_word;
            wire           hit;
            wire           wr_ctrl;
            wire           start;
            wire [3:0]     ticks;
            wire           tick;
            wire           gate;
            wire           count_edge;
            wire           reload;
            wire           cap_evt;
            wire           cmp_raw;

            assign hit     = bank_ok & (ch_sel == i[1:0]);
            assign wr_ctrl = wr & hit & (ofs == `TCP_OFS_CTRL);
            assign start   = wr_ctrl & wdata[`TCP_CTRL_START];

            // Source 0 is every clock; the others are external tick strobes.
            assign ticks = {src_tick_in, 1'b1};
            assign tick  = ticks[src_ff];
            // The inputs are used as they come; the far side keeps them synchronous.
            assign gate  = (mode_ff == `TCP_MODE_GATED) ? en_in[i] : 1'b1;
            assign count_edge = (st_ff == ST_RUN) & en_ff & tick & gate;
            assign reload  = start | trst_in[i];
            assign cap_evt = cap_in[i] & ~cap_prev_ff;

            // ----------------------------------------------------
            // Configuration registers.
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    period_ff  <= `TCP_PERIOD_RST;
                    compare_ff <= `TCP_COMPARE_RST;
                    en_ff      <= 1'b0;
                    comp_ff    <= 1'b0;
                    mode_ff    <= `TCP_MODE_FREE;
                    src_ff     <= 2'h0;
                    rel_ff     <= `TCP_REL_LESS;
                    db_ff      <= `TCP_DB_RST;
                end else if (wr & hit) begin
                    case (ofs)
                        `TCP_OFS_CTRL: begin
                            en_ff   <= wdata[`TCP_CTRL_EN];
                            mode_ff <= wdata[`TCP_CTRL_MODE +: 2];
                            rel_ff  <= wdata[`TCP_CTRL_REL +: 3];
                            src_ff  <= wdata[`TCP_CTRL_SRC +: 2];
                            comp_ff <= wdata[`TCP_CTRL_COMP];
                            db_ff   <= wdata[`TCP_CTRL_DB +: DBW];
                        end
                        `TCP_OFS_PERIOD: begin
                            period_ff <= wdata[CW-1:0];
                        end
                        `TCP_OFS_COMPARE: begin
                            compare_ff <= wdata[CW-1:0];
                        end
                        default: begin
                            period_ff <= period_ff;
                        end
                    endcase
                end
            end

            // ----------------------------------------------------
            // Next count and run state.
            always @* begin
                nxt_cnt = cnt_ff;
                nxt_st  = st_ff;
                case (st_ff)
                    ST_IDLE: begin
                        if (start) begin
                            nxt_st = ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (count_edge && cnt_ff == {CW{1'b0}}) begin
                            if (mode_ff == `TCP_MODE_ONESHOT) begin
                                nxt_st = ST_HALT;
                            end else begin
                                nxt_cnt = period_ff;
                            end
                        end else if (count_edge) begin
                            nxt_cnt = cnt_ff - {{(CW-1){1'b0}}, 1'b1};
                        end
                    end
                    ST_HALT: begin
                        if (reload) begin
                            nxt_st = ST_RUN;
                        end
                    end
                    default: begin
                        nxt_st = ST_IDLE;
                    end
                endcase
                // A start or timer reset outranks the count in the same cycle.
                if (reload) begin
                    nxt_cnt = period_ff;
                end
            end

            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    cnt_ff <= `TCP_COUNT_RST;
                    st_ff  <= ST_IDLE;
                    tc_ff  <= 1'b0;
                end else begin
                    cnt_ff <= nxt_cnt;
                    st_ff  <= nxt_st;
                    // High exactly while a running count rests at zero.
                    tc_ff  <= (nxt_st == ST_RUN) & (nxt_cnt == {CW{1'b0}});
                end
            end

            // ----------------------------------------------------
            // Capture on the rising edge of the capture input.
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    cap_prev_ff <= 1'b0;
                    cap_ff      <= {CW{1'b0}};
                    cap_full_ff <= 1'b0;
                end else begin
                    cap_prev_ff <= cap_in[i];
                    if (cap_evt) begin
                        cap_ff      <= cnt_ff;
                        cap_full_ff <= 1'b1;
                    end else if (rd & hit & (ofs == `TCP_OFS_CAPTURE)) begin
                        cap_full_ff <= 1'b0;
                    end
                end
            end

            // ----------------------------------------------------
            // Compare output, kill and deadband.
            assign cmp_raw = (st_ff != ST_IDLE) & cmp_rel(rel_ff, cnt_ff, compare_ff);

            tcp_deadband #(
                .DBW     (DBW)
            ) u_db (
                .clk     (clk),
                .rst     (rst),
                .pwm_in  (cmp_raw),
                .comp_en (comp_ff),
                .kill    (kill_in[i]),
                .db_len  (db_ff),
                .out_p   (cmp_out[i]),
                .out_n   (cmp_n_out[i])
            );

            assign tc_out[i] = tc_ff;

            // ----------------------------------------------------
            // Read view of this channel.
            always @* begin
                rd_word = `TCP_WORD_ZERO;
                case (ofs)
                    `TCP_OFS_CTRL: begin
                        rd_word[`TCP_CTRL_EN]         = en_ff;
                        rd_word[`TCP_CTRL_MODE +: 2]  = mode_ff;
                        rd_word[`TCP_CTRL_REL +: 3]   = rel_ff;
                        rd_word[`TCP_CTRL_SRC +: 2]   = src_ff;
                        rd_word[`TCP_CTRL_COMP]       = comp_ff;
                        rd_word[`TCP_CTRL_DB +: DBW]  = db_ff;
                    end
                    `TCP_OFS_PERIOD: begin
                        rd_word[CW-1:0] = period_ff;
                    end
                    `TCP_OFS_COMPARE: begin
                        rd_word[CW-1:0] = compare_ff;
                    end
                    `TCP_OFS_COUNT: begin
                        // Plain look at the live count; the counter is untouched.
                        rd_word[CW-1:0] = cnt_ff;
                    end
                    `TCP_OFS_CAPTURE: begin
                        rd_word[CW-1:0] = cap_ff;
                    end
                    `TCP_OFS_STATUS: begin
                        rd_word[5:0] = {cap_full_ff, cmp_raw, tc_ff, st_ff};
                    end
                    default: begin
                        rd_word = `TCP_WORD_ZERO;
                    end
                endcase
            end

            assign ch_rd[i*32 +: 32] = rd_word;
        end
    endgenerate

    // ============================================================
    // Read data register: valid only in the cycle after the strobe.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= `TCP_WORD_ZERO;
        end else if (rd && bank_ok) begin
            rdata <= ch_rd[ch_sel*32 +: 32];
        end else begin
            rdata <= `TCP_WORD_ZERO;
        end
    end

endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the four-channel timer, counter and PWM unit.
`timescale 1ns/100ps
`default_nettype none
`include "tcp_consts.vh"
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [2:0]  src_tick_in;
    logic [3:0]  cap_in, trst_in, en_in, kill_in, cmp_out, cmp_n_out, tc_out;
    logic [3:0]  req_cap = 4'h0, req_trst = 4'h0, req_en = 4'h0, req_kill = 4'h0;
    logic        rd_seen = 1'b0;
    logic [31:0] seed = 32'h0001_3d4e;
    logic [31:0] rnd;
    logic [31:0] per [4];
    logic [31:0] exp_q [$];
    logic [31:0] msk_q [$];
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n_rise, n_high, n_cmp, n_cmpn;

    tcp_top #(.NCH(4), .CW(16), .DBW(8), .AW(8)) i_dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .src_tick_in(src_tick_in), .cap_in(cap_in), .trst_in(trst_in), .en_in(en_in),
        .kill_in(kill_in), .cmp_out(cmp_out), .cmp_n_out(cmp_n_out), .tc_out(tc_out));
    tcp_fabric_model i_fab (
        .clk(clk), .rst(rst), .req_cap(req_cap), .req_trst(req_trst), .req_en(req_en),
        .req_kill(req_kill), .src_tick_in(src_tick_in), .cap_in(cap_in),
        .trst_in(trst_in), .en_in(en_in), .kill_in(kill_in));

    always #20 clk = ~clk;

    // ============================================================
    // Helpers.
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    // Strobes are left as set; the next call overwrites them one edge later.
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [1:0] ch, input logic [2:0] ofs, input logic [31:0] d);
        bus(1'b1, 1'b0, {1'b0, ch, ofs, 2'b00}, d);
    endtask

    task automatic rreg(input logic [1:0] ch, input logic [2:0] ofs, input logic [31:0] e,
                        input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, 1'b1, {1'b0, ch, ofs, 2'b00}, 32'h0000_0000);
    endtask

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, addr, 32'h0000_0000);
    endtask

    // Counts tc rises and high cycles of both compare outputs on one channel.
    task automatic watch(input int n, input int ch);
        logic prev;
        prev = tc_out[ch];
        {n_rise, n_high, n_cmp, n_cmpn} = '0;
        repeat (n) begin
            idle(1);
            n_rise += int'(tc_out[ch] & ~prev);
            n_high += int'(tc_out[ch]);
            n_cmp += int'(cmp_out[ch]);
            n_cmpn += int'(cmp_n_out[ch]);
            prev = tc_out[ch];
        end
    endtask

    // ============================================================
    // Read answers are compared against the oldest note in the queue.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_seen <= rd;
        if (rd_seen) begin
            total_checks++;
            if ((rdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
                fail_count++;
                $display("MISMATCH %0t read %h expected %h", $time, rdata, exp_q[0]);
            end
            exp_q.delete(0);
            msk_q.delete(0);
        end
        if (cyc == 6000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ============================================================
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            rreg(c[1:0], `TCP_OFS_CTRL, 32'h0, 32'hffff_ffff);
            rreg(c[1:0], `TCP_OFS_PERIOD, 32'h0000_ffff, 32'hffff_ffff);
            rreg(c[1:0], `TCP_OFS_COUNT, 32'h0000_ffff, 32'hffff_ffff);
            rreg(c[1:0], `TCP_OFS_STATUS, 32'h0000_0001, 32'h0000_003f);
            per[c] = xs() & 32'h0000_ffff;
            wreg(c[1:0], `TCP_OFS_PERIOD, per[c]);
        end
        for (int c = 0; c < 4; c++) rreg(c[1:0], `TCP_OFS_PERIOD, per[c], 32'hffff_ffff);
        // Idle channels 1 to 3 see random control lines; channel 0 stays under test control.
        rnd = xs();
        {req_cap, req_trst, req_en, req_kill} <= rnd[15:0] & 16'heeee;
        exp_q.push_back(32'h0);
        msk_q.push_back(32'hffff_ffff);
        bus(1'b0, 1'b1, 8'h80, 32'h0);
        wreg(0, `TCP_OFS_COUNT, 32'h0000_1234);
        rreg(0, `TCP_OFS_COUNT, 32'h0000_ffff, 32'hffff_ffff);
        // Free run, period 2, every clock: tc once per three cycles.
        wreg(0, `TCP_OFS_PERIOD, 32'h2);
        wreg(0, `TCP_OFS_CTRL, 32'h3);
        idle(3);
        watch(30, 0);
        chk(n_rise == 10 && n_high == 10, "free run tc");
        repeat (3) rreg(0, `TCP_OFS_COUNT, 32'h0, 32'hffff_fffc);
        watch(30, 0);
        chk(n_rise == 10, "tc disturbed by reads");
        for (int k = 1; k < 4; k++) begin
            wreg(0, `TCP_OFS_CTRL, 32'h3 | (k << `TCP_CTRL_SRC));
            idle(30);
            watch(12 * (k + 1), 0);
            chk(n_rise == 4, "tick source");
        end
        wreg(0, `TCP_OFS_COMPARE, 32'h1);
        for (int r = 0; r < 5; r++) begin
            wreg(0, `TCP_OFS_CTRL, 32'h1 | (r << `TCP_CTRL_REL));
            idle(4);
            watch(30, 0);
            chk(n_cmp == ((r == 1 || r == 3) ? 20 : 10) && n_cmpn == 0, "relation");
        end
        req_kill[0] <= 1'b1;
        idle(4);
        watch(30, 0);
        chk(n_cmp == 0, "kill");
        req_kill[0] <= 1'b0;
        wreg(0, `TCP_OFS_PERIOD, 32'h9);
        wreg(0, `TCP_OFS_COMPARE, 32'h5);
        wreg(0, `TCP_OFS_CTRL, 32'h0001_0203);
        idle(20);
        watch(40, 0);
        chk(n_cmp == 12 && n_cmpn == 12, "deadband pair");
        wreg(0, `TCP_OFS_PERIOD, 32'h3);
        wreg(0, `TCP_OFS_CTRL, 32'h7);
        idle(12);
        rreg(0, `TCP_OFS_COUNT, 32'h0, 32'hffff_ffff);
        rreg(0, `TCP_OFS_STATUS, 32'h4, 32'h7);
        chk(tc_out[0] === 1'b0, "one-shot tc");
        // Gated mode holds the count while enable is low.
        wreg(0, `TCP_OFS_PERIOD, 32'h0000_a5c3);
        wreg(0, `TCP_OFS_CTRL, 32'hb);
        idle(5);
        rreg(0, `TCP_OFS_COUNT, 32'h0000_a5c3, 32'hffff_ffff);
        req_en[0] <= 1'b1;
        idle(3);
        req_en[0] <= 1'b0;
        idle(4);
        rreg(0, `TCP_OFS_COUNT, 32'h0000_a5c0, 32'hffff_ffff);
        req_cap[0] <= 1'b1;
        idle(1);
        req_cap[0] <= 1'b0;
        idle(4);
        rreg(0, `TCP_OFS_STATUS, 32'h20, 32'h20);
        rreg(0, `TCP_OFS_CAPTURE, 32'h0000_a5c0, 32'hffff_ffff);
        rreg(0, `TCP_OFS_STATUS, 32'h0, 32'h20);
        req_trst[0] <= 1'b1;
        idle(1);
        req_trst[0] <= 1'b0;
        idle(4);
        rreg(0, `TCP_OFS_COUNT, 32'h0000_a5c3, 32'hffff_ffff);
        idle(3);
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* sim/tcp_fabric_model.sv */
// Fabric-side model: count tick sources and synchronised control lines.
`timescale 1ns/100ps
`default_nettype none
module tcp_fabric_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Requests from the bench.
    input  wire logic [3:0] req_cap,
    input  wire logic [3:0] req_trst,
    input  wire logic [3:0] req_en,
    input  wire logic [3:0] req_kill,
    // Lines into the unit.
    output var  logic [2:0] src_tick_in,
    output var  logic [3:0] cap_in,
    output var  logic [3:0] trst_in,
    output var  logic [3:0] en_in,
    output var  logic [3:0] kill_in
);
    logic [3:0] div_ff;

    // ============================================================
    // Every line leaves a flop on the unit's clock, so nothing changes mid-cycle.
    // Tick source k strobes once every k+2 cycles; a 12-step divider serves all three.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff <= 4'h0;
            src_tick_in <= 3'h0;
            {cap_in, trst_in, en_in, kill_in} <= 16'h0000;
        end else begin
            div_ff <= (div_ff == 4'hb) ? 4'h0 : div_ff + 4'h1;
            src_tick_in <= {div_ff % 4 == 0, div_ff % 3 == 0, div_ff % 2 == 0};
            {cap_in, trst_in, en_in, kill_in} <= {req_cap, req_trst, req_en, req_kill};
        end
    end
endmodule
`default_nettype wire

/* sim/tcp_top_checker.sv */
// Concurrent checks on the ports of the timer, counter and PWM unit.
`timescale 1ns/100ps
`default_nettype none
`include "tcp_consts.vh"
module tcp_top_checker #(
    parameter NCH = 4,
    parameter CW  = 16,
    parameter DBW = 8,
    parameter AW  = 8
) (
    // Clock and reset.
    input wire logic           clk,
    input wire logic           rst,
    // Register port.
    input wire logic [AW-1:0]  addr,
    input wire logic [31:0]    wdata,
    input wire logic           wr,
    input wire logic           rd,
    input wire logic [31:0]    rdata,
    // Channel lines.
    input wire logic [2:0]     src_tick_in,
    input wire logic [NCH-1:0] cap_in,
    input wire logic [NCH-1:0] trst_in,
    input wire logic [NCH-1:0] en_in,
    input wire logic [NCH-1:0] kill_in,
    input wire logic [NCH-1:0] cmp_out,
    input wire logic [NCH-1:0] cmp_n_out,
    input wire logic [NCH-1:0] tc_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ============================================================
    // Register reads.
    rd_idle_zero_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    count_width_a: assert property ($past(rd) && $past(addr[4:2]) == `TCP_OFS_COUNT
        |-> rdata[31:16] == 16'h0000) else $error("count read wider than 16 bits");
    cap_width_a: assert property ($past(rd) && $past(addr[4:2]) == `TCP_OFS_CAPTURE
        |-> rdata[31:16] == 16'h0000) else $error("capture read wider than 16 bits");
    state_onehot_a: assert property ($past(rd) && !$past(addr[7])
        && $past(addr[4:2]) == `TCP_OFS_STATUS |-> $onehot(rdata[2:0]))
        else $error("run state is not one-hot");
    status_tc_a: assert property ($past(rd) && !$past(addr[7])
        && $past(addr[4:2]) == `TCP_OFS_STATUS |-> rdata[3] == $past(tc_out[addr[6:5]]))
        else $error("status tc differs from tc output");

    // ============================================================
    // Compare outputs.
    kill_out_a: assert property (kill_in != 0
        |=> ((cmp_out | cmp_n_out) & $past(kill_in)) == 0) else $error("kill ignored");
    db_excl_a: assert property ((cmp_out & cmp_n_out) == 0)
        else $error("both compare outputs high");
    db_gap_a: assert property ($rose(cmp_n_out[0]) |-> !$past(cmp_out[0]))
        else $error("complement rose without a gap");

    cover property ($rose(tc_out[0]));
    cover property ($rose(cmp_n_out[0]));
    cover property (kill_in[0] && cmp_out[0]);
    cover property ($rose(cap_in[0]));
endmodule

bind tcp_top tcp_top_checker #(.NCH(NCH), .CW(CW), .DBW(DBW), .AW(AW)) i_chk (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .src_tick_in(src_tick_in), .cap_in(cap_in), .trst_in(trst_in), .en_in(en_in),
    .kill_in(kill_in), .cmp_out(cmp_out), .cmp_n_out(cmp_n_out), .tc_out(tc_out));
`default_nettype wire
